// file: flash_cmd_defs.svh
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// ----------------------------------------------------------------------------
// Command opcodes seen on the serial input.
// ----------------------------------------------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS_WRITE_A 8'h01
`define OP_STATUS_WRITE_B 8'h31
`define OP_CONFIG_WRITE 8'h11
`define OP_READ_EXT_ADDR 8'hc8
`define OP_WRITE_EXT_ADDR 8'hc5
`define OP_ENTER_4BYTE 8'hb7
`define OP_EXIT_4BYTE 8'he9
`define OP_READ_DATA 8'h03

// ----------------------------------------------------------------------------
// Frame lengths in serial clocks, counted from the first opcode bit; LEN_ADDR_3BYTE and LEN_ADDR_4BYTE count the address bits alone.
// ----------------------------------------------------------------------------
`define LEN_OPCODE_ONLY 7'd8
`define LEN_ONE_DATA 7'd16
`define LEN_TWO_DATA 7'd24
`define LEN_ADDR_3BYTE 7'd24
`define LEN_ADDR_4BYTE 7'd32
`define LEN_FULL_4BYTE 7'd40
`define LEN_SATURATE 7'h7f

// ----------------------------------------------------------------------------
// Field positions and masks.
// ----------------------------------------------------------------------------
`define STATUS_BUSY_BIT 0
`define STATUS_LATCH_BIT 1
`define SR_WRITE_MASK 16'h7bfc
`define CFG_MODE_BIT 0
`define CFG_STRAP_BIT 1
`define EXT_LIVE_MASK 8'h03

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define STATUS_RESET 16'h0000
`define CONFIG_RESET 8'h00
`define EXT_ADDR_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing: register write cycle time and the system clock period.
// ----------------------------------------------------------------------------
`define REG_WRITE_CYCLE_TIME_US 5000
`define CLOCK_PERIOD_PS 25000
`define REG_WRITE_CYCLES ((`REG_WRITE_CYCLE_TIME_US * 1000) / (`CLOCK_PERIOD_PS / 1000))

`endif

// file: flash_cmd_front.sv
`timescale 1ns/1ps

`include "flash_cmd_defs.svh"

module flash_cmd_front #(
	parameter int unsigned WRITE_CYCLE_CLOCKS = `REG_WRITE_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SI_IN,
	input wire logic POWERUP_ADDR_MODE_IN,
	input wire logic [7:0] MEM_DATA_IN,
	output logic SO_OUT,
	output logic SO_OE_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	output flash_cmd_pkg::reg_view_type REGS_OUT
);
	import flash_cmd_pkg::*;

	// ------------------------------------------------------------------------
	// Elaboration checks.
	// ------------------------------------------------------------------------
	if (WRITE_CYCLE_CLOCKS < 1) begin : g_bad_cycle
		$error("WRITE_CYCLE_CLOCKS must be at least one");
	end

	localparam logic [31:0] CYCLE_LAST = 32'(WRITE_CYCLE_CLOCKS - 1); // Last timer count.

	// Forms the memory address from the received address and the mode.
	function automatic logic [31:0] form_addr(input logic [31:0] raw, input logic four,
			input logic [1:0] ext);
		if (four) begin
			form_addr = raw;
		end else begin
			form_addr = {6'h00, ext, raw[23:0]};
		end
	endfunction

	// Number of address bits for the current mode.
	function automatic logic [6:0] addr_len(input logic four);
		addr_len = four ? `LEN_ADDR_4BYTE : `LEN_ADDR_3BYTE;
	endfunction

	sys_state_type s_reg;     // System clock domain state.
	sys_state_type s_next;    // Its next value.
	link_rise_type r_reg;     // Serial rising edge state.
	link_rise_type r_next;    // Its next value.
	link_fall_type f_reg;     // Serial falling edge state.
	link_fall_type f_next;    // Its next value.
	logic frame_start_reg;    // High until the first clock of a frame.
	logic cs_rise;            // Synchronised chip select rising edge.
	logic write_enable_latch; // Write enable latch, status bit 1.
	logic write_in_progress_flag; // Self-timed write cycle busy, status bit 0.
	logic current_addr_mode_flag; // Current address mode, 1 is 4-byte.
	logic [15:0] sr_data; // Status data received in the frame.
	logic cmd_ok; // Register write may start.

	// Named views of the register bits that steer the frame decode.
	assign write_enable_latch = s_reg.regs.status[`STATUS_LATCH_BIT];
	assign write_in_progress_flag = s_reg.regs.status[`STATUS_BUSY_BIT];
	assign current_addr_mode_flag = s_reg.regs.cfg[`CFG_MODE_BIT];
	assign cs_rise = s_reg.cs_sync[1] & ~s_reg.cs_sync[2];
	assign cmd_ok = cs_rise & write_enable_latch & ~write_in_progress_flag;

	// ------------------------------------------------------------------------
	// System domain: command execution at the end of each frame.
	// ------------------------------------------------------------------------

	// Status data: one byte keeps the high half, two bytes take both.
	always_comb begin
		if (r_reg.bit_cnt == `LEN_TWO_DATA) begin
			sr_data = {r_reg.shift[7:0], r_reg.shift[15:8]};
		end else begin
			sr_data = {s_reg.regs.status[15:8], r_reg.shift[7:0]};
		end
	end

	// Next state of the system domain. The link registers are read only at
	// the synchronised chip select rise, when the serial clock stands still.
	always_comb begin
		s_next = s_reg;
		s_next.cs_sync = {s_reg.cs_sync[1:0], CS_N_IN};
		s_next.strap_sync = {s_reg.strap_sync[0], POWERUP_ADDR_MODE_IN};
		if (s_reg.init_cnt != 2'h3) begin
			s_next.init_cnt = s_reg.init_cnt + 2'h1;
		end
		// Load the power-up mode once the strap has settled.
		if (s_reg.init_cnt == 2'h2) begin
			s_next.regs.cfg[`CFG_STRAP_BIT] = s_reg.strap_sync[1];
			s_next.regs.cfg[`CFG_MODE_BIT] = s_reg.strap_sync[1];
		end
		// Self-timed cycle: busy for WRITE_CYCLE_CLOCKS, then busy and latch clear.
		if (write_in_progress_flag) begin
			if (s_reg.timer == CYCLE_LAST) begin
				s_next.timer = 32'h0;
				s_next.regs.status[`STATUS_BUSY_BIT] = 1'b0;
				s_next.regs.status[`STATUS_LATCH_BIT] = 1'b0;
			end else begin
				s_next.timer = s_reg.timer + 32'h1;
			end
		end else if (cs_rise) begin
			// A frame has just ended while idle: decode it.
			unique case (r_reg.opcode)
				`OP_WRITE_ENABLE: begin
					if (r_reg.bit_cnt == `LEN_OPCODE_ONLY) begin
						s_next.regs.status[`STATUS_LATCH_BIT] = 1'b1;
					end
				end
				`OP_STATUS_WRITE_A, `OP_STATUS_WRITE_B: begin
					// Accepted only with the latch set and on a byte boundary.
					if (cmd_ok && (r_reg.bit_cnt == `LEN_ONE_DATA ||
							r_reg.bit_cnt == `LEN_TWO_DATA)) begin
						s_next.regs.status = (s_reg.regs.status & ~`SR_WRITE_MASK) |
							(sr_data & `SR_WRITE_MASK);
						s_next.regs.status[`STATUS_BUSY_BIT] = 1'b1;
						s_next.timer = 32'h0;
					end
				end
				`OP_CONFIG_WRITE: begin
					if (cmd_ok && r_reg.bit_cnt == `LEN_ONE_DATA) begin
						s_next.regs.cfg[7:1] = r_reg.shift[7:1];
						s_next.regs.status[`STATUS_BUSY_BIT] = 1'b1;
						s_next.timer = 32'h0;
					end
				end
				`OP_WRITE_EXT_ADDR: begin
					if (cmd_ok && r_reg.bit_cnt == `LEN_ONE_DATA) begin
						s_next.regs.ext_addr = r_reg.shift[7:0] & `EXT_LIVE_MASK;
					end
				end
				`OP_ENTER_4BYTE: begin
					if (r_reg.bit_cnt == `LEN_OPCODE_ONLY) begin
						s_next.regs.cfg[`CFG_MODE_BIT] = 1'b1;
					end
				end
				`OP_EXIT_4BYTE: begin
					if (r_reg.bit_cnt == `LEN_OPCODE_ONLY) begin
						s_next.regs.cfg[`CFG_MODE_BIT] = 1'b0;
					end
				end
				`OP_READ_DATA: begin
					// A full 4-byte address replaces the extended bits.
					if (current_addr_mode_flag && r_reg.bit_cnt >= `LEN_FULL_4BYTE) begin
						s_next.regs.ext_addr = {6'h00, r_reg.shift[25:24]};
					end
				end
				default: begin
					s_next.timer = s_reg.timer;
				end
			endcase
		end
	end

	// System domain register, cleared to fixed values by the reset.
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			s_reg <= '{cs_sync: 3'h7, strap_sync: 2'h0, init_cnt: 2'h0, timer: 32'h0,
				regs: '{status: `STATUS_RESET, cfg: `CONFIG_RESET,
				ext_addr: `EXT_ADDR_RESET}};
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------------
	// Link domain: frame start marker.
	// ------------------------------------------------------------------------

	// Set while chip select is high, cleared by the first clock of a frame.
	always_ff @(posedge SCLK_IN or posedge CS_N_IN) begin
		if (CS_N_IN) begin
			frame_start_reg <= 1'b1;
		end else begin
			frame_start_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Link domain: sampling on the rising serial clock.
	// ------------------------------------------------------------------------

	// Shifts in opcode and address, then steps the read address per byte.
	always_comb begin
		r_next = r_reg;
		r_next.view_sync1 = {write_in_progress_flag, current_addr_mode_flag,
			s_reg.regs.ext_addr[1:0]};
		r_next.view_sync2 = r_reg.view_sync1;
		if (frame_start_reg) begin
			r_next.bit_cnt = 7'd1;
			r_next.opcode = {7'h00, SI_IN};
			r_next.shift = 32'h0;
			r_next.data_bit = 3'h0;
			r_next.reading = 1'b0;
			r_next.read_busy = 1'b0;
		end else begin
			if (r_reg.bit_cnt != `LEN_SATURATE) begin
				r_next.bit_cnt = r_reg.bit_cnt + 7'd1;
			end
			if (r_reg.bit_cnt < `LEN_OPCODE_ONLY) begin
				r_next.opcode = {r_reg.opcode[6:0], SI_IN};
			end else if (!r_reg.reading) begin
				r_next.shift = {r_reg.shift[30:0], SI_IN};
			end
			// Note whether the device was busy when a read opcode arrived.
			if (r_reg.bit_cnt == 7'd7 && {r_reg.opcode[6:0], SI_IN} == `OP_READ_DATA) begin
				r_next.read_busy = r_reg.view_sync2[3];
			end
			if (r_reg.reading) begin
				r_next.data_bit = r_reg.data_bit + 3'h1;
				if (r_reg.data_bit == 3'h7) begin
					r_next.mem_addr = r_reg.mem_addr + 32'h1;
				end
			end else if (r_reg.opcode == `OP_READ_DATA && !r_reg.read_busy &&
					r_reg.bit_cnt == 7'd7 + addr_len(r_reg.view_sync2[2])) begin
				r_next.reading = 1'b1;
				r_next.data_bit = 3'h0;
				r_next.mem_addr = form_addr({r_reg.shift[30:0], SI_IN}, r_reg.view_sync2[2],
					r_reg.view_sync2[1:0]);
			end
		end
	end

	// Rising edge register.
	always_ff @(posedge SCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			r_reg <= '{bit_cnt: 7'h00, opcode: 8'h00, shift: 32'h0, data_bit: 3'h0,
				mem_addr: 32'h0, reading: 1'b0, read_busy: 1'b0, view_sync1: 4'h0,
				view_sync2: 4'h0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------------------
	// Link domain: driving the output on the falling serial clock.
	// ------------------------------------------------------------------------

	// Read data or the extended register leave MSB first.
	always_comb begin
		logic [2:0] ext_idx; // Bit position within the extended register.
		logic [7:0] ext_val; // Extended register as seen in the link domain.
		ext_idx = 3'(r_reg.bit_cnt - `LEN_OPCODE_ONLY);
		ext_val = {6'h00, r_reg.view_sync2[1:0]};
		f_next.so = 1'b0;
		f_next.so_oe = 1'b0;
		if (r_reg.reading) begin
			f_next.so = MEM_DATA_IN[~r_reg.data_bit];
			f_next.so_oe = 1'b1;
		end else if (r_reg.opcode == `OP_READ_EXT_ADDR &&
				r_reg.bit_cnt >= `LEN_OPCODE_ONLY) begin
			f_next.so = ext_val[~ext_idx];
			f_next.so_oe = 1'b1;
		end
	end

	// Falling edge register, released only inside a frame.
	always_ff @(negedge SCLK_IN or negedge NRST_IN or posedge CS_N_IN) begin
		if (!NRST_IN || CS_N_IN) begin
			f_reg <= '{so: 1'b0, so_oe: 1'b0};
		end else begin
			f_reg <= f_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------------
	assign SO_OUT = f_reg.so;
	assign SO_OE_OUT = f_reg.so_oe;
	assign MEM_ADDR_OUT = r_reg.mem_addr;
	assign REGS_OUT = s_reg.regs;

	// ------------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------------

	a_status_write_gate: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cs_rise && !write_enable_latch && !write_in_progress_flag &&
		r_reg.opcode == `OP_STATUS_WRITE_A |=> !write_in_progress_flag)
		else $error("status write accepted without latch");

	a_fixed_bits: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$stable(s_reg.regs.status[15]) && $stable(s_reg.regs.status[10]))
		else $error("protected status bit changed");

	a_bad_length: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cs_rise && !write_in_progress_flag && r_reg.opcode == `OP_STATUS_WRITE_A &&
		r_reg.bit_cnt != `LEN_ONE_DATA && r_reg.bit_cnt != `LEN_TWO_DATA
		|=> !write_in_progress_flag)
		else $error("misframed status write executed");

	a_low_only: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cmd_ok && r_reg.opcode == `OP_STATUS_WRITE_A && r_reg.bit_cnt == `LEN_ONE_DATA
		|=> write_in_progress_flag && $stable(s_reg.regs.status[15:8]))
		else $error("one byte status write touched high byte");

	a_cycle_end: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		write_in_progress_flag && s_reg.timer == CYCLE_LAST
		|=> !write_in_progress_flag && !write_enable_latch)
		else $error("write cycle end did not clear flags");

	a_config_start: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cmd_ok && r_reg.opcode == `OP_CONFIG_WRITE && r_reg.bit_cnt == `LEN_ONE_DATA
		|=> write_in_progress_flag ##1 write_in_progress_flag &&
		s_reg.regs.cfg[7:1] == $past(r_reg.shift[7:1], 2))
		else $error("config write did not start busy cycle");

	a_ext_upper: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		s_reg.regs.ext_addr[7:2] == 6'h00)
		else $error("unimplemented extended bits set");

	a_ext_write: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cmd_ok && r_reg.opcode == `OP_WRITE_EXT_ADDR && r_reg.bit_cnt == `LEN_ONE_DATA
		|=> s_reg.regs.ext_addr == ($past(r_reg.shift[7:0]) & `EXT_LIVE_MASK))
		else $error("extended register write lost");

	a_strap_load: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		s_reg.init_cnt == 2'h2 |=> current_addr_mode_flag == $past(s_reg.strap_sync[1]))
		else $error("power-up address mode not loaded");

	a_quiet_deselect: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		CS_N_IN |-> !f_reg.so_oe && !f_reg.so)
		else $error("output driven while deselected");

	a_enter_mode: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cs_rise && !write_in_progress_flag && r_reg.opcode == `OP_ENTER_4BYTE &&
		r_reg.bit_cnt == `LEN_OPCODE_ONLY |=> current_addr_mode_flag)
		else $error("enter 4-byte mode missed");

	a_exit_mode: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cs_rise && !write_in_progress_flag && r_reg.opcode == `OP_EXIT_4BYTE &&
		r_reg.bit_cnt == `LEN_OPCODE_ONLY |=> !current_addr_mode_flag)
		else $error("exit 4-byte mode missed");

	a_addr_step: assert property (@(posedge SCLK_IN) disable iff (!NRST_IN || CS_N_IN)
		!frame_start_reg && r_reg.reading && r_reg.data_bit == 3'h7
		|=> r_reg.mem_addr == $past(r_reg.mem_addr) + 32'h1)
		else $error("read address did not advance");

	a_busy_quiet: assert property (@(negedge SCLK_IN) disable iff (!NRST_IN || CS_N_IN)
		r_reg.read_busy |-> !f_reg.so_oe || r_reg.opcode != `OP_READ_DATA)
		else $error("read served while busy");

	c_status_two: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		cmd_ok && r_reg.opcode == `OP_STATUS_WRITE_A && r_reg.bit_cnt == `LEN_TWO_DATA);
	c_mode_enter: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$rose(current_addr_mode_flag));
	c_read_wrap: cover property (@(posedge SCLK_IN) disable iff (!NRST_IN || CS_N_IN)
		r_reg.reading && r_reg.data_bit == 3'h7);
	c_ext_read: cover property (@(negedge SCLK_IN) disable iff (!NRST_IN || CS_N_IN)
		f_reg.so_oe && r_reg.opcode == `OP_READ_EXT_ADDR);
	c_busy_read: cover property (@(posedge SCLK_IN) disable iff (!NRST_IN || CS_N_IN)
		r_reg.read_busy && r_reg.opcode == `OP_READ_DATA);

endmodule // flash_cmd_front

// file: flash_cmd_front_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Self-checking bench for the flash command front-end.
// ----------------------------------------------------------------------------
module flash_cmd_front_tb;
	import flash_cmd_pkg::*;

	typedef struct {
		logic [39:0] cmd; // Frame bits, left aligned.
		int nb;           // Number of bits sent.
		logic busy;       // Busy expected just after the frame.
		logic [15:0] st;  // Status expected once idle.
		logic [7:0] ext;  // Extended address expected.
		logic mode;       // Address mode expected.
	} row_type;

	logic clk, rst_n, cs_n, sclk, si, strap, so, so_oe, oe_seen;
	logic [7:0] mem;
	logic [31:0] addr, rd;
	reg_view_type regs;
	int errors = 0;
	int check_count = 0;

	// Register writes, refusals and mode commands, in execution order.
	row_type rows[16] = '{
		'{40'h0600000000, 8, 1'b0, 16'h0002, 8'h00, 1'b0},
		'{40'h01ff000000, 16, 1'b1, 16'h00fc, 8'h00, 1'b0},
		'{40'h0100000000, 16, 1'b0, 16'h00fc, 8'h00, 1'b0},
		'{40'h0600000000, 8, 1'b0, 16'h00fe, 8'h00, 1'b0},
		'{40'h31ffff0000, 24, 1'b1, 16'h7bfc, 8'h00, 1'b0},
		'{40'h0600000000, 8, 1'b0, 16'h7bfe, 8'h00, 1'b0},
		'{40'h0100000000, 12, 1'b0, 16'h7bfe, 8'h00, 1'b0},
		'{40'h0100000000, 16, 1'b1, 16'h7b00, 8'h00, 1'b0},
		'{40'h0600000000, 8, 1'b0, 16'h7b02, 8'h00, 1'b0},
		'{40'h1100000000, 16, 1'b1, 16'h7b00, 8'h00, 1'b0},
		'{40'h0600000000, 8, 1'b0, 16'h7b02, 8'h00, 1'b0},
		'{40'hc503000000, 16, 1'b0, 16'h7b02, 8'h03, 1'b0},
		'{40'hc5ff000000, 16, 1'b0, 16'h7b02, 8'h03, 1'b0},
		'{40'h1100000000, 24, 1'b0, 16'h7b02, 8'h03, 1'b0},
		'{40'hb700000000, 8, 1'b0, 16'h7b02, 8'h03, 1'b1},
		'{40'he900000000, 8, 1'b0, 16'h7b02, 8'h03, 1'b0}
	};

	flash_cmd_front #(.WRITE_CYCLE_CLOCKS(200)) dut (
		.CLOCK_IN(clk), .NRST_IN(rst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SI_IN(si),
		.POWERUP_ADDR_MODE_IN(strap), .MEM_DATA_IN(mem), .SO_OUT(so), .SO_OE_OUT(so_oe),
		.MEM_ADDR_OUT(addr), .REGS_OUT(regs)
	);

	host_link_model host (
		.so_in(so), .so_oe_in(so_oe), .addr_in(addr), .cs_n_out(cs_n),
		.sclk_out(sclk), .si_out(si), .mem_out(mem)
	);

	// System clock of 25 ns.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Expected memory byte, worked out independently of the model.
	function automatic logic [7:0] img(input logic [31:0] a);
		return a[7:0] ^ {a[25:24], 6'h15};
	endfunction

	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Waits, bounded, for the write cycle to finish.
	task automatic settle();
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (regs.status[0] !== 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("busy_done", 32'h0, {31'h0, regs.status[0]});
	endtask

	// Applies reset for six clocks with the given strap and checks the cleared view.
	task automatic do_reset(input logic s);
		@(negedge clk);
		rst_n = 1'b0;
		strap = s;
		repeat (6) @(negedge clk);
		chk("regs_in_reset", 32'h0, regs);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// A hang is cut short well beyond the expected run of some 110 us.
	initial begin
		#(1000000);
		errors++;
		$display("mismatch watchdog expected done seen hang");
		conclude();
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		strap = 1'b0;
		do_reset(1'b0);
		chk("ext_after_reset", 32'h0, regs.ext_addr);
		chk("mode_after_reset", 32'h0, regs.cfg[0]);
		foreach (rows[i]) begin
			host.frame(rows[i].cmd, rows[i].nb, 0, rd, oe_seen);
			chk("busy", rows[i].busy, regs.status[0]);
			settle();
			chk("status", rows[i].st, regs.status);
			chk("ext", rows[i].ext, regs.ext_addr);
			chk("mode", rows[i].mode, regs.cfg[0]);
		end
		// The host rereads the extended register after leaving 4-byte mode.
		host.frame(40'hc800000000, 8, 16, rd, oe_seen);
		chk("ext_read", 32'h0303, rd);
		chk("ext_read_oe", 32'h1, oe_seen);
		// A 3-byte read takes its top byte from the extended register.
		host.frame({8'h03, 24'h123456, 8'h00}, 32, 16, rd, oe_seen);
		chk("read3_data", {img(32'h03123456), img(32'h03123457)}, rd);
		chk("read3_addr", 32'h03123458, addr);
		// A 4-byte read replaces the extended bits with its own.
		host.frame(40'hb700000000, 8, 0, rd, oe_seen);
		host.frame({8'h03, 32'h02abcdef}, 40, 8, rd, oe_seen);
		chk("read4_data", img(32'h02abcdef), rd);
		chk("read4_addr", 32'h02abcdf0, addr);
		repeat (6) @(negedge clk);
		chk("read4_ext", 32'h02, regs.ext_addr);
		host.frame(40'he900000000, 8, 0, rd, oe_seen);
		// Back in 3-byte mode the host rereads the segment bits left by the 4-byte read.
		host.frame(40'hc800000000, 8, 16, rd, oe_seen);
		chk("ext_read2", 32'h0202, rd);
		// A read issued during a write cycle produces nothing and spares the cycle.
		host.frame(40'h0600000000, 8, 0, rd, oe_seen);
		host.frame(40'h0100000000, 16, 0, rd, oe_seen);
		host.frame({8'h03, 24'h000010, 8'h00}, 32, 8, rd, oe_seen);
		chk("busy_read_oe", 32'h0, oe_seen);
		settle();
		chk("busy_read_status", 32'h7b00, regs.status);
		// A second reset with the strap set starts in 4-byte mode, extended bits clear.
		do_reset(1'b1);
		chk("ext_reset2", 32'h0, regs.ext_addr);
		chk("mode_reset2", 32'h1, regs.cfg[0]);
		chk("strap_bit", 32'h1, regs.cfg[1]);
		conclude();
	end
endmodule // flash_cmd_front_tb

// file: flash_cmd_pkg.sv
package flash_cmd_pkg;

	// Software visible registers, held together as the block's register view.
	typedef struct packed {
		logic [15:0] status;  // Status register, bit 1 write enable latch, bit 0 busy.
		logic [7:0] cfg;      // Configuration register, bit 0 current address mode.
		logic [7:0] ext_addr; // Extended address register, upper six bits zero.
	} reg_view_type;

	// State of the system clock domain.
	typedef struct packed {
		logic [2:0] cs_sync;    // Chip select synchroniser plus edge history.
		logic [1:0] strap_sync; // Power-up address mode strap synchroniser.
		logic [1:0] init_cnt;   // Cycles since reset release.
		logic [31:0] timer;     // Self-timed write cycle counter.
		reg_view_type regs;     // Register view.
	} sys_state_type;

	// State of the serial clock rising edge domain.
	typedef struct packed {
		logic [6:0] bit_cnt;    // Bits sampled in this frame, saturating.
		logic [7:0] opcode;     // Opcode shift register.
		logic [31:0] shift;     // Address and data bits after the opcode.
		logic [2:0] data_bit;   // Bit position within the output byte.
		logic [31:0] mem_addr;  // Memory address being read.
		logic reading;          // Read data phase is active.
		logic read_busy;        // Read opcode arrived while a cycle was busy.
		logic [3:0] view_sync1; // First stage: busy, mode, extended bits 1:0.
		logic [3:0] view_sync2; // Second stage of the same.
	} link_rise_type;

	// State of the serial clock falling edge domain.
	typedef struct packed {
		logic so;    // Serial output level.
		logic so_oe; // Serial output enable.
	} link_fall_type;

endpackage

// file: host_link_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host side of the serial link: mode 0 frames and a combinational memory.
// ----------------------------------------------------------------------------
module host_link_model (
	input wire logic so_in,
	input wire logic so_oe_in,
	input wire logic [31:0] addr_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic si_out,
	output logic [7:0] mem_out
);
	localparam time HALF = 80; // Half of the 160 ns link clock period.

	// Memory image: the byte depends on the low address byte and the segment bits.
	assign mem_out = addr_in[7:0] ^ {addr_in[25:24], 6'h15};

	// The link is idle with chip select high and the clock standing low.
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b0;
	end

	// Sends nb bits of cmd MSB first, then clocks nr more bits and gathers SO.
	// The caller chooses nb, so it decides whether the frame ends on a byte.
	task automatic frame(input logic [39:0] cmd, input int nb, input int nr,
		output logic [31:0] rd, output logic oe_seen);
		rd = '0;
		oe_seen = 1'b0;
		cs_n_out = 1'b0;
		#(HALF);
		for (int i = 0; i < nb + nr; i++) begin
			// Data bits first; afterwards the line toggles so no stale value lingers.
			si_out = (i < nb) ? cmd[39 - i] : ~si_out;
			#(HALF);
			sclk_out = 1'b1;
			if (i >= nb) begin
				rd = {rd[30:0], so_in};
				oe_seen = oe_seen | so_oe_in;
			end
			#(HALF);
			sclk_out = 1'b0;
		end
		#(HALF);
		cs_n_out = 1'b1;
		si_out = ~si_out;
		// Chip select stays high well beyond the three system clocks of sync time.
		#(400);
	endtask
endmodule // host_link_model
